/* File: include/fsps_pkg.sv */
/*
  Shared constants and types of the flash self-programming sequencer:
  register offsets, control bit positions, flash geometry, timing figures, states.
  Assumes nothing beyond a SystemVerilog compiler; nothing is imported.
*/
package fsps_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;  // selfprog_control_reg
  localparam logic [7:0] OFF_POINTER = 8'h04;  // 16-bit byte pointer
  localparam logic [7:0] OFF_DATA    = 8'h08;  // word from the r1:r0 pair
  localparam logic [7:0] OFF_CMD     = 8'h0c;  // store/load-program strobes
  localparam logic [7:0] OFF_LOAD    = 8'h10;  // load-program result byte
  localparam logic [7:0] OFF_STATUS  = 8'h14;  // boot start, halt, blocked, eeprom busy

  // control register bit positions
  localparam int CTRL_EN_BIT    = 0;  // selfprog_enable_bit
  localparam int CTRL_ERASE_BIT = 1;  // page_erase_bit
  localparam int CTRL_WRITE_BIT = 2;  // page_write_bit
  localparam int CTRL_REEN_BIT  = 4;  // rw_area_reenable_bit
  localparam int CTRL_BUSY_BIT  = 6;  // rw_area_busy_flag, read only

  // command register bit positions
  localparam int CMD_STORE_BIT = 0;
  localparam int CMD_LOAD_BIT  = 1;

  // status register field positions
  localparam int STAT_EE_BIT      = 0;
  localparam int STAT_BLOCKED_BIT = 1;
  localparam int STAT_HALT_BIT    = 2;
  localparam int STAT_BOOT_LSB    = 16;

  // reset values
  localparam logic [15:0] PTR_RST  = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // flash geometry in words
  localparam int          PC_W       = 15;
  localparam int          WORD_AW    = 7;
  localparam int          PAGE_AW    = 8;
  localparam int          PAGE_WORDS = 128;
  localparam logic [7:0]  RWW_PAGES  = 8'he0;      // 224 read-while-write pages, blocked while busy
  localparam logic [14:0] RWW_LAST   = 15'h6fff;
  localparam logic [14:0] NO_READ_WHILE_WRITE_AREA_FIRST = 15'h7000;
  localparam logic [14:0] FLASH_TOP  = 15'h7fff;
  localparam logic [14:0] BOOT_START_512W  = 15'h7e00;
  localparam logic [14:0] BOOT_START_1024W = 15'h7c00;
  localparam logic [14:0] BOOT_START_2048W = 15'h7800;
  localparam logic [14:0] BOOT_START_4096W = 15'h7000;

  // timing: pclk cycles for the timed window, programming time in ns
  localparam logic [2:0] WINDOW_CYC  = 3'h4;
  localparam int         PROG_MIN_NS = 3700000;
  localparam int         PROG_MAX_NS = 4500000;

  typedef enum logic [1:0] {
    FSPS_IDLE,
    FSPS_ARMED,
    FSPS_STREAM,
    FSPS_PROG
  } fsps_state_t;

endpackage

/* File: include/fsps_buf_if.sv */
/*
  Port bundle between the sequencer and its temporary page buffer.
  Assumes one clock shared by both ends; read data is registered in the buffer.
*/
`timescale 1ns/1ps
`default_nettype none

interface fsps_buf_if #(
  parameter int AW = 7,
  parameter int DW = 16
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport owner (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem   (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

/* File: rtl/fsps_page_buf.sv */
/*
  Temporary page buffer: one word per location, one write and one read port.
  Assumes the owner holds raddr for a cycle; rdata follows one edge later.
*/
`timescale 1ns/1ps
`default_nettype none

module fsps_page_buf #(
  parameter int DEPTH = 128
) (
  input  wire logic  clk,
  fsps_buf_if.mem    bus
);
  logic [15:0] mem_q [DEPTH];

  // no reset on the array: contents are undefined until filled
  always_ff @(posedge clk) begin
    if (bus.we) begin
      mem_q[bus.waddr] <= bus.wdata;
    end
    bus.rdata <= mem_q[bus.raddr];
  end
endmodule // fsps_page_buf

`default_nettype wire

/* File: rtl/fsps_sequencer.sv */
/*
  Flash self-programming sequencer with an APB register slave: page erase,
  temporary buffer fill, page write, re-enable of the read-while-write area,
  boot area decode and load-program byte reads.
  Assumes the flash array outside takes erase/write strobes and answers a read
  address one cycle later, and that rc_osc_tick is a one-cycle strobe from the
  calibrated RC oscillator, already synchronous to pclk.
*/
// The register addresses and the APB interface to the registers were chosen for this implementation.
// What this block and the software driving it do
// RULE1 - program and erase time is counted in RC oscillator ticks, not pclk
// RULE2 - each erase or write lasts between 3.7 ms and 4.5 ms
// RULE3 - two-bit boot size places the boot area at the top, ending 0x7fff
// RULE4 - pages below 224 are read-while-write, the top 32 pages are not
// RULE5 - word addresses are fifteen bits wide
// RULE6 - a page holds 128 words, low seven address bits pick the word
// RULE7 - page number for erase and write comes from pointer bits 15 to 8
// RULE8 - pointer bits 7 to 1 select the buffer word, zero for page write
// RULE9 - pointer bit 0 is zero for stores and selects the byte for loads
// RULE10 - during erase or write only the no-read-while-write area is readable
// RULE11 - erase plus enable, then a store, erases the pointed page
// RULE12 - write plus enable, then a store, writes the buffer to the page
// RULE13 - enable alone, then a store, puts the data word into the buffer
// RULE14 - re-enable plus enable, then a store, frees the read-while-write area
// RULE15 - busy flag is set while the read-while-write area is unreadable
// RULE16 - software waits for enable to read zero before the next command
// RULE17 - software waits for eeprom write busy clear before writing control
// RULE18 - software masks interrupts around the timed control write
// RULE19 - the store must come within four cycles of the control write
// RULE20 - busy flag clears only through the re-enable command
// RULE21 - an eeprom write in progress blocks all programming commands
// RULE22 - a page write to the top area halts the processor until done
// RULE23 - enable clears by itself on completion or when the window lapses
`timescale 1ns/1ps
`default_nettype none

module fsps_sequencer #(
  parameter int RC_TICK_NS = 1000,
  parameter int PROG_TICKS = (fsps_pkg::PROG_MIN_NS + RC_TICK_NS - 1) / RC_TICK_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rc_osc_tick,
  input  wire logic        eeprom_write_busy_flag,
  input  wire logic [1:0]  boot_size_select,
  input  wire logic [14:0] cpu_fetch_addr,
  input  wire logic [15:0] flash_rd_data,
  output logic      [14:0] flash_rd_addr,
  output logic             flash_erase,
  output logic      [7:0]  flash_page,
  output logic             flash_wr_en,
  output logic      [14:0] flash_wr_addr,
  output logic      [15:0] flash_wr_data,
  output logic             rw_area_busy_flag,
  output logic             fetch_blocked,
  output logic             cpu_halt,
  output logic      [14:0] boot_start
);

  fsps_pkg::fsps_state_t state_q;
  logic        selfprog_enable_bit_q;
  logic        page_erase_bit_q;
  logic        page_write_bit_q;
  logic        rw_area_reenable_bit_q;
  logic        busy_q;
  logic [2:0]  win_q;
  logic [15:0] ptr_q;
  logic [15:0] data_q;
  logic [7:0]  page_index_q;
  logic [7:0]  wcnt_q;
  logic        rd_vld_q;
  logic [6:0]  rd_idx_q;
  logic [15:0] tick_cnt_q;
  logic        ld_pend_q;
  logic        ld_byte_sel_q;
  logic [7:0]  load_byte_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        flash_erase_q;
  logic        flash_wr_en_q;
  logic [14:0] flash_wr_addr_q;
  logic [15:0] flash_wr_data_q;
  logic [14:0] flash_rd_addr_q;
  logic        fetch_blocked_q;
  logic        cpu_halt_q;
  logic [14:0] boot_start_q;

  logic        wr_acc;
  logic        wr_ctrl;
  logic        wr_ptr;
  logic        wr_data;
  logic        wr_cmd;
  logic        rd_hit;
  logic [31:0] rdata_d;
  logic        store_req;
  logic        load_req;
  logic        ctrl_accept;
  logic        armed_store;
  logic        do_erase;
  logic        do_write;
  logic        do_reenable;
  logic        do_fill;
  logic        prog_done;
  logic        stream_done;
  logic [31:0] ctrl_view;
  logic [31:0] status_view;

  fsps_buf_if #(.AW(fsps_pkg::WORD_AW), .DW(16)) buf_bus ();

  fsps_page_buf #(
    .DEPTH (fsps_pkg::PAGE_WORDS)
  ) u_page_buf (
    .clk (pclk),
    .bus (buf_bus.mem)
  );

  // address decode; a write lands in the access cycle, where pready is high
  assign wr_acc = psel & penable & pwrite;
  always_comb begin
    wr_ctrl = 1'b0;
    wr_ptr  = 1'b0;
    wr_data = 1'b0;
    wr_cmd  = 1'b0;
    rd_hit  = 1'b1;
    if (paddr == fsps_pkg::OFF_CTRL) begin
      wr_ctrl = wr_acc;
    end else if (paddr == fsps_pkg::OFF_POINTER) begin
      wr_ptr = wr_acc;
    end else if (paddr == fsps_pkg::OFF_DATA) begin
      wr_data = wr_acc;
    end else if (paddr == fsps_pkg::OFF_CMD) begin
      wr_cmd = wr_acc;
    end else if (paddr == fsps_pkg::OFF_LOAD || paddr == fsps_pkg::OFF_STATUS) begin
      rd_hit = 1'b1;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // register views as software reads them
  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[fsps_pkg::CTRL_EN_BIT]    = selfprog_enable_bit_q;
    ctrl_view[fsps_pkg::CTRL_ERASE_BIT] = page_erase_bit_q;
    ctrl_view[fsps_pkg::CTRL_WRITE_BIT] = page_write_bit_q;
    ctrl_view[fsps_pkg::CTRL_REEN_BIT]  = rw_area_reenable_bit_q;
    ctrl_view[fsps_pkg::CTRL_BUSY_BIT]  = busy_q;  // [RULE15]
    status_view = 32'h0000_0000;
    status_view[fsps_pkg::STAT_EE_BIT]      = eeprom_write_busy_flag;
    status_view[fsps_pkg::STAT_BLOCKED_BIT] = fetch_blocked_q;
    status_view[fsps_pkg::STAT_HALT_BIT]    = cpu_halt_q;
    status_view[fsps_pkg::STAT_BOOT_LSB +: fsps_pkg::PC_W] = boot_start_q;
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (paddr == fsps_pkg::OFF_CTRL) begin
      rdata_d = ctrl_view;
    end else if (paddr == fsps_pkg::OFF_POINTER) begin
      rdata_d = {16'h0000, ptr_q};
    end else if (paddr == fsps_pkg::OFF_DATA) begin
      rdata_d = {16'h0000, data_q};
    end else if (paddr == fsps_pkg::OFF_LOAD) begin
      rdata_d = {24'h000000, load_byte_q};
    end else if (paddr == fsps_pkg::OFF_STATUS) begin
      rdata_d = status_view;
    end
  end

  // apb answer: read data and pready are set up in the setup cycle,
  // so every transfer finishes in its first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~rd_hit;
      if (psel & ~penable & ~pwrite) begin
        prdata_q <= rdata_d;
      end
    end
  end

  // command decode inside the timed window
  assign store_req   = wr_cmd & pwdata[fsps_pkg::CMD_STORE_BIT];
  assign load_req    = wr_cmd & pwdata[fsps_pkg::CMD_LOAD_BIT];
  assign ctrl_accept = wr_ctrl & pwdata[fsps_pkg::CTRL_EN_BIT] & (state_q == fsps_pkg::FSPS_IDLE)
                       & ~eeprom_write_busy_flag;  // [RULE21]
  assign armed_store = store_req & (state_q == fsps_pkg::FSPS_ARMED)
                       & ~ptr_q[0];  // [RULE9]
  assign do_erase    = armed_store & page_erase_bit_q;  // [RULE11]
  assign do_write    = armed_store & ~page_erase_bit_q & page_write_bit_q
                       & (ptr_q[7:1] == 7'h00);  // [RULE12] [RULE8]
  assign do_reenable = armed_store & ~page_erase_bit_q & ~page_write_bit_q
                       & rw_area_reenable_bit_q;  // [RULE14]
  assign do_fill     = armed_store & ~page_erase_bit_q & ~page_write_bit_q
                       & ~rw_area_reenable_bit_q;  // [RULE13]
  assign stream_done = (state_q == fsps_pkg::FSPS_STREAM) & (wcnt_q == 8'(fsps_pkg::PAGE_WORDS));
  assign prog_done   = (state_q == fsps_pkg::FSPS_PROG) & rc_osc_tick
                       & (tick_cnt_q == 16'(PROG_TICKS - 1));  // [RULE1] [RULE2]

  // buffer fill uses pointer bits 7..1, so each word steps the pointer by two
  assign buf_bus.we    = do_fill;  // [RULE13]
  assign buf_bus.waddr = ptr_q[7:1];  // [RULE8]
  assign buf_bus.wdata = data_q;
  assign buf_bus.raddr = wcnt_q[6:0];

  // sequencer state and control bits; a lapsed window drops the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q                <= fsps_pkg::FSPS_IDLE;
      selfprog_enable_bit_q  <= 1'b0;
      page_erase_bit_q       <= 1'b0;
      page_write_bit_q       <= 1'b0;
      rw_area_reenable_bit_q <= 1'b0;
      win_q                  <= 3'h0;
    end else begin
      case (state_q)
        fsps_pkg::FSPS_IDLE: begin
          if (ctrl_accept) begin
            state_q                <= fsps_pkg::FSPS_ARMED;
            selfprog_enable_bit_q  <= 1'b1;
            page_erase_bit_q       <= pwdata[fsps_pkg::CTRL_ERASE_BIT];
            page_write_bit_q       <= pwdata[fsps_pkg::CTRL_WRITE_BIT];
            rw_area_reenable_bit_q <= pwdata[fsps_pkg::CTRL_REEN_BIT];
            win_q                  <= fsps_pkg::WINDOW_CYC - 3'h1;  // [RULE19]
          end
        end
        fsps_pkg::FSPS_ARMED: begin
          if (do_erase) begin
            state_q <= fsps_pkg::FSPS_PROG;
          end else if (do_write) begin
            state_q <= fsps_pkg::FSPS_STREAM;
          end else if (store_req || win_q == 3'h0) begin
            // fill, re-enable, illegal pointer or lapsed window
            state_q                <= fsps_pkg::FSPS_IDLE;  // [RULE23] [RULE19]
            selfprog_enable_bit_q  <= 1'b0;
            page_erase_bit_q       <= 1'b0;
            page_write_bit_q       <= 1'b0;
            rw_area_reenable_bit_q <= 1'b0;
          end else begin
            win_q <= win_q - 3'h1;
          end
        end
        fsps_pkg::FSPS_STREAM: begin
          if (stream_done) begin
            state_q <= fsps_pkg::FSPS_PROG;
          end
        end
        fsps_pkg::FSPS_PROG: begin
          if (prog_done) begin
            state_q                <= fsps_pkg::FSPS_IDLE;
            selfprog_enable_bit_q  <= 1'b0;  // [RULE23]
            page_erase_bit_q       <= 1'b0;
            page_write_bit_q       <= 1'b0;
          end
        end
        default: begin
          state_q <= fsps_pkg::FSPS_IDLE;
        end
      endcase
    end
  end

  // pointer and data word; frozen while a page operation runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q  <= fsps_pkg::PTR_RST;
      data_q <= fsps_pkg::DATA_RST;
    end else if (state_q == fsps_pkg::FSPS_IDLE || state_q == fsps_pkg::FSPS_ARMED) begin
      if (wr_ptr) begin
        ptr_q <= pwdata[15:0];
      end
      if (wr_data) begin
        data_q <= pwdata[15:0];
      end
    end
  end

  // page number latched at the store, erase strobe one cycle long
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_index_q  <= 8'h00;
      flash_erase_q <= 1'b0;
    end else begin
      flash_erase_q <= do_erase;  // [RULE11]
      if (do_erase || do_write) begin
        page_index_q <= ptr_q[15:8];  // [RULE7]
      end
    end
  end

  // page write streams the buffer out; read data lags its address by one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt_q          <= 8'h00;
      rd_vld_q        <= 1'b0;
      rd_idx_q        <= 7'h00;
      flash_wr_en_q   <= 1'b0;
      flash_wr_addr_q <= 15'h0000;
      flash_wr_data_q <= 16'h0000;
    end else begin
      if (state_q == fsps_pkg::FSPS_STREAM && !stream_done) begin
        wcnt_q <= wcnt_q + 8'h01;
      end else if (state_q != fsps_pkg::FSPS_STREAM) begin
        wcnt_q <= 8'h00;
      end
      rd_vld_q      <= (state_q == fsps_pkg::FSPS_STREAM) && !stream_done;
      rd_idx_q      <= wcnt_q[6:0];
      flash_wr_en_q <= rd_vld_q;  // [RULE12]
      if (rd_vld_q) begin
        flash_wr_addr_q <= {page_index_q, rd_idx_q};  // [RULE5] [RULE6]
        flash_wr_data_q <= buf_bus.rdata;
      end
    end
  end

  // programming time counted in oscillator ticks, whatever pclk runs at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 16'h0000;
    end else if (state_q != fsps_pkg::FSPS_PROG) begin
      tick_cnt_q <= 16'h0000;
    end else if (rc_osc_tick) begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;  // [RULE1]
    end
  end

  // busy flag: set by erase or write, cleared by the re-enable command only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (do_erase || do_write) begin
      busy_q <= 1'b1;  // [RULE15] [RULE20]
    end else if (do_reenable) begin
      busy_q <= 1'b0;  // [RULE14] [RULE20]
    end
  end

  // fetch guard while the busy flag is set, processor halt while a page write to a top-area page (RWW_PAGES and up) runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_blocked_q <= 1'b0;
      cpu_halt_q      <= 1'b0;
    end else begin
      fetch_blocked_q <= busy_q && (cpu_fetch_addr <= fsps_pkg::RWW_LAST);  // [RULE10] [RULE4]
      cpu_halt_q      <= (state_q == fsps_pkg::FSPS_STREAM || state_q == fsps_pkg::FSPS_PROG)
                         && !prog_done && page_write_bit_q
                         && (page_index_q >= fsps_pkg::RWW_PAGES);  // [RULE22] [RULE4]
    end
  end

  // boot area start from the size select; always ends at the top word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_start_q <= fsps_pkg::BOOT_START_4096W;
    end else begin
      case (boot_size_select)  // [RULE3]
        2'h3:    boot_start_q <= fsps_pkg::BOOT_START_512W;
        2'h2:    boot_start_q <= fsps_pkg::BOOT_START_1024W;
        2'h1:    boot_start_q <= fsps_pkg::BOOT_START_2048W;
        default: boot_start_q <= fsps_pkg::BOOT_START_4096W;
      endcase
    end
  end

  // load-program read; a busy read-while-write area gives no data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_rd_addr_q <= 15'h0000;
      ld_pend_q       <= 1'b0;
      ld_byte_sel_q   <= 1'b0;
      load_byte_q     <= 8'h00;
    end else begin
      ld_pend_q <= 1'b0;
      if (load_req && !(busy_q && ptr_q[15:1] <= fsps_pkg::RWW_LAST)) begin  // [RULE10]
        flash_rd_addr_q <= ptr_q[15:1];  // [RULE5]
        ld_byte_sel_q   <= ptr_q[0];  // [RULE9]
        ld_pend_q       <= 1'b1;
      end
      if (ld_pend_q) begin
        load_byte_q <= ld_byte_sel_q ? flash_rd_data[15:8] : flash_rd_data[7:0];  // [RULE9]
      end
    end
  end

  // every output comes straight from a flop
  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign flash_rd_addr     = flash_rd_addr_q;
  assign flash_erase       = flash_erase_q;
  assign flash_page        = page_index_q;
  assign flash_wr_en       = flash_wr_en_q;
  assign flash_wr_addr     = flash_wr_addr_q;
  assign flash_wr_data     = flash_wr_data_q;
  assign rw_area_busy_flag = busy_q;
  assign fetch_blocked     = fetch_blocked_q;
  assign cpu_halt          = cpu_halt_q;
  assign boot_start        = boot_start_q;

endmodule // fsps_sequencer

`default_nettype wire

/* File: test/fsps_flash_model.sv */
/*
  Far-side stand-in: flash array read port and calibrated rc oscillator tick.
  Assumes the sequencer reads with a held address and takes one-cycle ticks.
*/
`timescale 1ns/1ps
`default_nettype none

module fsps_flash_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [14:0] flash_rd_addr,
  output logic      [15:0] flash_rd_data,
  output logic             rc_osc_tick
);
  logic [2:0] div_q;

  // rc tick every 8 pclk, free running so program time ignores pclk traffic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end
  assign rc_osc_tick = (div_q == 3'h7);

  // word carries its own address, so high and low bytes differ
  assign flash_rd_data = {1'b1, flash_rd_addr};
endmodule // fsps_flash_model

`default_nettype wire

/* File: test/fsps_seq_assertions.sv */
/*
  Port-level checks of the sequencer.
  Bound into every fsps_sequencer; one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module fsps_seq_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        flash_erase,
  input wire logic [7:0]  flash_page,
  input wire logic        flash_wr_en,
  input wire logic [14:0] flash_wr_addr,
  input wire logic        rw_area_busy_flag,
  input wire logic [14:0] cpu_fetch_addr,
  input wire logic        fetch_blocked,
  input wire logic        cpu_halt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // flash strobes against busy and page
  a_erase_one_pulse: assert property (flash_erase |=> !flash_erase)
    else $error("erase strobe longer than a cycle");
  a_erase_sets_busy: assert property (flash_erase |-> rw_area_busy_flag)
    else $error("erase without busy flag");
  a_write_page_addr: assert property (flash_wr_en |-> flash_wr_addr[14:7] == flash_page)
    else $error("write address outside latched page");
  a_write_word_step: assert property (flash_wr_en && flash_wr_addr[6:0] != 7'h7f |=>
    flash_wr_en && flash_wr_addr == $past(flash_wr_addr) + 15'h1)
    else $error("page burst broken");
  a_busy_only_store: assert property ($fell(rw_area_busy_flag) |->
    $past(psel && penable && pwrite && paddr == fsps_pkg::OFF_CMD))
    else $error("busy cleared without a store");
  a_halt_top_area: assert property (cpu_halt |-> flash_page >= fsps_pkg::RWW_PAGES)
    else $error("halt for a low page");
  // fetch blocking, judged only when inputs held two cycles
  a_fetch_blocked: assert property (
    (rw_area_busy_flag && cpu_fetch_addr <= fsps_pkg::RWW_LAST) [*2] |-> fetch_blocked)
    else $error("fetch into busy area let through");
  a_fetch_free: assert property ((!rw_area_busy_flag) [*2] |-> !fetch_blocked)
    else $error("fetch blocked while area free");
  // bus answer
  a_pready_next: assert property (psel && !penable |=> pready)
    else $error("no zero-wait answer");
  a_unmapped_err: assert property (pready && paddr > fsps_pkg::OFF_STATUS |-> pslverr)
    else $error("unmapped access without error");
endmodule // fsps_seq_assertions

bind fsps_sequencer fsps_seq_assertions u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pready, .pslverr, .flash_erase, .flash_page, .flash_wr_en, .flash_wr_addr, .rw_area_busy_flag,
  .cpu_fetch_addr, .fetch_blocked, .cpu_halt);

`default_nettype wire

/* File: test/flash_self_programming_sequencer_tb.sv */
/*
  Self-checking bench of the sequencer, driven as the cpu over apb.
  Assumes the flash model beside it; short program time via PROG_TICKS.
*/
`timescale 1ns/1ps
`default_nettype none

module flash_self_programming_sequencer_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        eeprom_write_busy_flag = 1'b0;
  logic [1:0]  boot_size_select = 2'h0;
  logic [14:0] cpu_fetch_addr = 15'h7000, flash_rd_addr, flash_wr_addr, boot_start;
  logic        pready, pslverr, rc_osc_tick, flash_erase, flash_wr_en, rerr;
  logic        rw_area_busy_flag, fetch_blocked, cpu_halt, halt_seen = 1'b0;
  logic [15:0] flash_rd_data, flash_wr_data, word1 = 16'h0;
  logic [7:0]  flash_page, er_page = 8'h0, wr_page = 8'h0;
  int          errors = 0, n_checks = 0, n_erase = 0, n_wr = 0;
  logic [16:0] rows [4] = '{{2'h3, 15'h7e00}, {2'h2, 15'h7c00}, {2'h1, 15'h7800}, {2'h0, 15'h7000}};

  initial forever #4 pclk = ~pclk;

  fsps_sequencer #(.PROG_TICKS(3)) u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .rc_osc_tick, .eeprom_write_busy_flag, .boot_size_select,
    .cpu_fetch_addr, .flash_rd_data, .flash_rd_addr, .flash_erase, .flash_page, .flash_wr_en,
    .flash_wr_addr, .flash_wr_data, .rw_area_busy_flag, .fetch_blocked, .cpu_halt, .boot_start);
  fsps_flash_model u_flash (.pclk, .presetn, .flash_rd_addr, .flash_rd_data, .rc_osc_tick);

  // flash-side tallies, sampled at the edge like the array would
  always @(posedge pclk) begin
    if (flash_erase) begin
      n_erase++;
      er_page = flash_page;
    end
    if (flash_wr_en) begin
      n_wr++;
      wr_page = flash_wr_addr[14:7];
      if (flash_wr_addr[6:0] == 7'h01) word1 = flash_wr_data;
    end
    if (cpu_halt) halt_seen = 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one transfer; idle edge after release so no signal is set twice per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (pready !== 1'b1) errors++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // pointer, control, store inside the window, then poll until enable drops
  task automatic spm(input logic [15:0] ptr, input logic [7:0] ctl);
    int n;
    n = 0;
    apb(1'b1, fsps_pkg::OFF_POINTER, {16'h0, ptr});
    apb(1'b1, fsps_pkg::OFF_CTRL, {24'h0, ctl});
    apb(1'b1, fsps_pkg::OFF_CMD, 32'h1);
    do apb(1'b0, fsps_pkg::OFF_CTRL, 32'h0); while (rdat[0] !== 1'b0 && ++n < 200);
    if (rdat[0] !== 1'b0) errors++;
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    check({17'h0, boot_start}, 32'h7000);
    presetn <= 1'b1;
    // boot size rows: select in, boot start out
    foreach (rows[i]) begin
      boot_size_select <= rows[i][16:15];
      repeat (2) @(posedge pclk);
      check({17'h0, boot_start}, {17'h0, rows[i][14:0]});
    end
    apb(1'b0, fsps_pkg::OFF_POINTER, 32'h0);
    check(rdat, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, rerr}, 32'h1);
    // eeprom write running: control write must be ignored
    eeprom_write_busy_flag <= 1'b1;
    apb(1'b1, fsps_pkg::OFF_CTRL, 32'h3);
    apb(1'b0, fsps_pkg::OFF_CTRL, 32'h0);
    check(rdat, 32'h0);
    eeprom_write_busy_flag <= 1'b0;
    // enable lapses when no store follows
    apb(1'b1, fsps_pkg::OFF_CTRL, 32'h1);
    apb(1'b0, fsps_pkg::OFF_CTRL, 32'h0);
    check(rdat, 32'h1);
    repeat (2) @(posedge pclk);
    apb(1'b0, fsps_pkg::OFF_CTRL, 32'h0);
    check(rdat, 32'h0);
    // fill word 1, odd-pointer erase dropped, then a real erase
    apb(1'b1, fsps_pkg::OFF_DATA, 32'ha5c3);
    spm(16'h0002, 8'h01);
    spm(16'h1201, 8'h03);
    check(n_erase, 32'h0);
    cpu_fetch_addr <= 15'h0100;
    spm(16'h1200, 8'h03);
    check(n_erase, 32'h1);
    check({24'h0, er_page}, 32'h12);
    check(rdat, 32'h40);
    spm(16'h0000, 8'h11);
    check(rdat, 32'h0);
    // page write with word bits set is dropped; top-area write halts cpu
    spm(16'hf002, 8'h05);
    check(n_wr, 32'h0);
    spm(16'hf000, 8'h05);
    check(n_wr, 32'h80);
    check({16'h0, word1}, 32'ha5c3);
    check({24'h0, wr_page}, 32'hf0);
    check({31'h0, halt_seen}, 32'h1);
    check(rdat, 32'h40);
    // busy load refused, then low and high byte of word 0x101
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, fsps_pkg::OFF_POINTER, 32'h0201 + i);
      apb(1'b1, fsps_pkg::OFF_CMD, 32'h2);
      apb(1'b0, fsps_pkg::OFF_LOAD, 32'h0);
      check(rdat, i == 2 ? 32'h81 : 32'(i));
      if (i == 0) spm(16'h0000, 8'h11);
    end
    give_verdict;
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    give_verdict;
  end
endmodule // flash_self_programming_sequencer_tb

`default_nettype wire
